/* verilog/pulse_timer_map.vh */
// register map, field positions, reset values and divider masks of the pulse measure timer
`ifndef PULSE_TIMER_MAP_VH
`define PULSE_TIMER_MAP_VH

// byte addresses on the register bus (word aligned)
`define MODE_REG_ADDR      5'h00
`define START_REG_ADDR     5'h04
`define RESULT_REG_ADDR    5'h08
`define IRQ_REQ_REG_ADDR   5'h0c
`define COUNTER_REG_ADDR   5'h10

// mode register fields
`define MEAS_MODE_LSB      2
`define MEAS_MODE_MSB      3
`define OVF_FLAG_BIT       5
`define COUNT_SRC_LSB      6
`define COUNT_SRC_MSB      7

// start and interrupt request registers use bit 0
`define START_BIT          0
`define IRQ_REQ_BIT        0

// measurement mode encodings
`define MEAS_FALL_PERIOD   2'h0
`define MEAS_RISE_PERIOD   2'h1
`define MEAS_BOTH_WIDTH    2'h2
`define MEAS_NONE          2'h3

// count source encodings
`define SRC_DIV_TWO        2'h0
`define SRC_DIV_SIXTEEN    2'h1
`define SRC_DIV_SIXTYFOUR  2'h2
`define SRC_DIV_FIVETWELVE 2'h3

// prescaler masks: a tick fires when the masked prescaler bits are all ones
`define PRESC_WIDTH        9
`define MASK_DIV_TWO       9'h001
`define MASK_DIV_SIXTEEN   9'h00f
`define MASK_DIV_SIXTYFOUR 9'h03f
`define MASK_DIV_FIVETWELVE 9'h1ff

// reset values
`define MODE_RESET         8'h00
`define COUNTER_RESET      16'h0000
`define RESULT_RESET       16'h0000
`define COUNTER_ALL_ONES   16'hffff

`endif

/* verilog/input_sync_edge.v */
// two-stage synchroniser and tick-sampled edge detector for the measured pulse input
`timescale 1ns/1ps

module input_sync_edge (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire pin_level,
  input  wire sample_en,
  output wire rise,
  output wire fall
);

  reg sync_first;
  reg sync_second;
  reg tick_level;

  ////////////////////////////////////////////////////////////////////////////////
  // the first stage feeds only the second stage, to settle metastability
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first  <= pin_level;
      sync_second <= sync_first;
    end
  end

  // sample once per count source tick, so edges live in the count clock's time base
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_level <= 1'b0;
    end else if (sample_en) begin
      tick_level <= sync_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare consecutive tick samples
  assign rise = sample_en & sync_second & ~tick_level;
  assign fall = sample_en & ~sync_second & tick_level;

endmodule // input_sync_edge

/* verilog/pulse_period_width_timer.v */
// pulse period / pulse width measurement timer channel with an Avalon-MM register slave
`timescale 1ns/1ps
`include "pulse_timer_map.vh"

module pulse_period_width_timer (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        measure_pulse_input,
  input  wire        irq_accept,
  output reg         irq_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  reg  [7:0]                mode_ctl;        // mode field, source field; bit 5 unused here
  reg                       count_start;
  reg                       overflow_flag;
  reg                       ovf_clear_pending;
  reg                       first_edge_seen;
  reg  [15:0]               counter;
  reg  [15:0]               result;
  reg  [`PRESC_WIDTH-1:0]   prescaler;
  reg                       next_irq_req;
  reg  [31:0]               next_readdata;
  reg  [`PRESC_WIDTH-1:0]   tick_mask;
  reg                       valid_edge;

  wire                      bus_req;
  wire                      bus_go;
  wire                      wr_go;
  wire                      rd_go;
  wire                      wr_low_byte;
  wire                      mode_wr;
  wire                      start_wr;
  wire                      irq_wr;
  wire [1:0]                meas_mode;
  wire [1:0]                count_src;
  wire [1:0]                new_meas_mode;
  wire                      tick;
  wire                      run_tick;
  wire                      pulse_rise;
  wire                      pulse_fall;
  wire                      wrap;
  wire                      edge_irq;
  wire                      mode_change_irq;

  assign meas_mode     = mode_ctl[`MEAS_MODE_MSB:`MEAS_MODE_LSB];
  assign count_src     = mode_ctl[`COUNT_SRC_MSB:`COUNT_SRC_LSB];
  assign new_meas_mode = avs_writedata[`MEAS_MODE_MSB:`MEAS_MODE_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state, the access takes effect at the edge where
  // waitrequest is seen low, and the read data stand at that same edge
  assign bus_req     = avs_read | avs_write;
  assign bus_go      = bus_req & ~avs_waitrequest;
  assign wr_go       = avs_write & ~avs_waitrequest;
  assign rd_go       = avs_read & ~avs_waitrequest;
  assign wr_low_byte = wr_go & avs_byteenable[0];
  assign mode_wr     = wr_low_byte & (avs_address == `MODE_REG_ADDR);
  assign start_wr    = wr_low_byte & (avs_address == `START_REG_ADDR);
  assign irq_wr      = wr_low_byte & (avs_address == `IRQ_REQ_REG_ADDR);

  // waitrequest drops for exactly one cycle per access, then rises again
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_go) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped addresses read as zero
  always @* begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `MODE_REG_ADDR: begin
        next_readdata[7:0]           = mode_ctl;
        next_readdata[`OVF_FLAG_BIT] = overflow_flag;
      end
      `START_REG_ADDR: begin
        next_readdata[`START_BIT] = count_start;
      end
      `RESULT_REG_ADDR: begin
        next_readdata[15:0] = result;
      end
      `IRQ_REQ_REG_ADDR: begin
        next_readdata[`IRQ_REQ_BIT] = irq_req;
      end
      `COUNTER_REG_ADDR: begin
        next_readdata[15:0] = counter;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  // load the read data while waitrequest is still high, so they are stable when it drops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers; writes to the result register fall through and are ignored
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctl    <= `MODE_RESET;
      count_start <= 1'b0;
    end else begin
      if (mode_wr) begin
        // overflow flag position is not stored, so the written bit 5 cannot set or clear it
        mode_ctl <= avs_writedata[7:0] & 8'hdf;
      end
      if (start_wr) begin
        count_start <= avs_writedata[`START_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // free running prescaler off the main clock; a selected tap gives the count source
  always @* begin
    case (count_src)
      `SRC_DIV_TWO:        tick_mask = `MASK_DIV_TWO;
      `SRC_DIV_SIXTEEN:    tick_mask = `MASK_DIV_SIXTEEN;
      `SRC_DIV_SIXTYFOUR:  tick_mask = `MASK_DIV_SIXTYFOUR;
      `SRC_DIV_FIVETWELVE: tick_mask = `MASK_DIV_FIVETWELVE;
      default:             tick_mask = `MASK_DIV_TWO;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler <= {`PRESC_WIDTH{1'b0}};
    end else begin
      prescaler <= prescaler + {{(`PRESC_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // a source change mid-count can shorten one tick period; acceptable for a free divider
  assign tick     = ((prescaler & tick_mask) == tick_mask);
  assign run_tick = tick & count_start;

  ////////////////////////////////////////////////////////////////////////////////
  // measured input, synchronised and sampled once per count tick
  input_sync_edge u_input_sync_edge (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_level (measure_pulse_input),
    .sample_en (tick),
    .rise      (pulse_rise),
    .fall      (pulse_fall)
  );

  // pick the valid edges for the selected measurement
  always @* begin
    case (meas_mode)
      `MEAS_FALL_PERIOD: valid_edge = pulse_fall;
      `MEAS_RISE_PERIOD: valid_edge = pulse_rise;
      `MEAS_BOTH_WIDTH:  valid_edge = pulse_rise | pulse_fall;
      `MEAS_NONE:        valid_edge = 1'b0;
      default:           valid_edge = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter, result capture and first-edge tracking
  // the counter is deliberately not cleared at start; it resumes from wherever it was
  assign wrap = run_tick & ~valid_edge & (counter == `COUNTER_ALL_ONES);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter         <= `COUNTER_RESET;
      result          <= `RESULT_RESET;
      first_edge_seen <= 1'b0;
    end else begin
      if (!count_start) begin
        first_edge_seen <= 1'b0;
      end else if (run_tick & valid_edge) begin
        first_edge_seen <= 1'b1;
      end
      if (run_tick) begin
        if (valid_edge) begin
          result  <= counter;
          counter <= `COUNTER_RESET;
        end else begin
          counter <= counter + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // overflow flag: set by a wrap, cleared at the tick after a mode write while started;
  // a wrap in the clearing tick wins so no overflow is lost
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag     <= 1'b0;
      ovf_clear_pending <= 1'b0;
    end else begin
      if (wrap) begin
        overflow_flag <= 1'b1;
      end else if (run_tick & ovf_clear_pending) begin
        overflow_flag <= 1'b0;
      end
      if (mode_wr & count_start) begin
        ovf_clear_pending <= 1'b1;
      end else if (run_tick | ~count_start) begin
        ovf_clear_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt request bit: hardware sets win over software clear and over acceptance
  assign edge_irq        = run_tick & valid_edge & first_edge_seen;
  assign mode_change_irq = mode_wr & count_start & (new_meas_mode != meas_mode);

  always @* begin
    next_irq_req = irq_req;
    if (irq_accept) begin
      next_irq_req = 1'b0;
    end
    if (irq_wr & ~avs_writedata[`IRQ_REQ_BIT]) begin
      next_irq_req = 1'b0;
    end
    if (edge_irq | wrap | mode_change_irq) begin
      next_irq_req = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= next_irq_req;
    end
  end

endmodule // pulse_period_width_timer

/* bench/pulse_timer_props.sv */
// bus handshake and interrupt request checks on the pulse timer ports
`timescale 1ns/1ps
module pulse_timer_props (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        irq_accept,
  input wire        irq_req
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_wr_ans;
    avs_write && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_rd_seq;
    avs_read && avs_waitrequest |-> ##1 !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_rd_seq: assert property (p_rd_seq) else $error("read handshake wrong");
  property p_idle;
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > 5'h10 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_rd_hold;
    avs_read && !avs_waitrequest |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_irq_hold;
    irq_req && !irq_accept && !avs_write |=> irq_req;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped alone");
endmodule // pulse_timer_props

bind pulse_period_width_timer pulse_timer_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq_accept(irq_accept), .irq_req(irq_req));

/* bench/pulse_src.sv */
// external pulse source driving the measured input pin
`timescale 1ns/1ps
module pulse_src (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire [7:0] low_len,
  input  wire [7:0] high_len,
  output reg        level
);
  reg [7:0] cnt;
  // idle high; each level lasts its full length, well over two ticks
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n || !run) begin
      level <= 1'b1;
      cnt   <= 8'h00;
    end else if (cnt == 8'h00) begin
      level <= ~level;
      cnt   <= (level ? low_len : high_len) - 8'h01;
    end else begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule // pulse_src

/* bench/pulse_period_width_timer_tb.sv */
// register-level tests of the pulse period and width timer
`timescale 1ns/1ps
module pulse_period_width_timer_tb;
  reg         ref_clk, rst_n, avs_read, avs_write, irq_accept, run, lvl;
  reg  [4:0]  avs_address;
  reg  [3:0]  be;
  reg  [31:0] avs_writedata, q, c1;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, irq_req, pin;
  integer     n_mismatch, cmp_count, i, j, m, t;
  pulse_period_width_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .measure_pulse_input(pin),
    .irq_accept(irq_accept), .irq_req(irq_req));
  pulse_src src (.ref_clk(ref_clk), .rst_n(rst_n), .run(run), .low_len(8'h14), .high_len(8'h0c), .level(pin));
  ////////////////////////////////////////////////////////////////
  // one bus cycle; an idle edge first so strobes never change twice in a step
  task bus(input [4:0] a, input w, input [31:0] d);
    begin
      @(posedge ref_clk);
      avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= d;
      t = 0;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && t < 100) begin
        @(posedge ref_clk);
        t = t + 1;
      end
      // a handshake that never completes is a failure, not a silent pass
      if (t >= 100) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t bus timeout got %h expected %h", $time, t, 0);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task wr(input [4:0] a, input [31:0] d); bus(a, 1'b1, d); endtask
  task rd(input [4:0] a); bus(a, 1'b0, 32'h0); endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // wait for a request with a bound, note the pin level when it comes
  // the first edge lets a software clear that landed at the caller's edge settle
  task wait_irq;
    begin
      t = 0;
      @(posedge ref_clk);
      while (irq_req !== 1'b1 && t < 300) begin
        @(posedge ref_clk);
        t = t + 1;
      end
      lvl = pin;
      cmp(t < 300, 1);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #(50 * 20000);
    n_mismatch = n_mismatch + 1;
    conclude;
  end
  initial begin
    n_mismatch = 0; cmp_count = 0;
    rst_n = 0; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0; irq_accept = 0; run = 0;
    be = 4'hf;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(5'h00); cmp(q, 32'h0);
    rd(5'h14); cmp(q, 32'h0);
    wr(5'h08, 32'h1234); rd(5'h08); cmp(q, 32'h0);
    wr(5'h00, 32'h20); rd(5'h00); cmp(q, 32'h0);
    // a write with the low byte lane off must not start the counter
    be <= 4'he;
    wr(5'h04, 32'h1);
    be <= 4'hf;
    rd(5'h04); cmp(q, 32'h0);
    $display("register test done");
    wr(5'h04, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      wr(5'h00, i << 6);
      rd(5'h10); c1 = q;
      repeat (4 * (i == 0 ? 2 : i == 1 ? 16 : i == 2 ? 64 : 512) - 3) @(posedge ref_clk);
      rd(5'h10); cmp((q - c1) & 32'hffff, 32'h4);
    end
    wr(5'h04, 32'h0); rd(5'h10); c1 = q;
    repeat (40) @(posedge ref_clk);
    rd(5'h10); cmp(q, c1);
    $display("count test done");
    wr(5'h00, 32'h0); wr(5'h04, 32'h1); wr(5'h0c, 32'h0);
    wr(5'h00, 32'h8); rd(5'h0c); cmp(q, 32'h1);
    wr(5'h0c, 32'h0); wr(5'h00, 32'h8); rd(5'h0c); cmp(q, 32'h0);
    wr(5'h00, 32'h0);
    @(posedge ref_clk) cmp(irq_req, 1'b1);
    irq_accept <= 1'b1;
    @(posedge ref_clk) irq_accept <= 1'b0;
    @(posedge ref_clk) cmp(irq_req, 1'b0);
    $display("request test done");
    for (m = 0; m < 3; m = m + 1) begin
      run <= 1'b0; wr(5'h04, 32'h0); wr(5'h00, m << 2); wr(5'h04, 32'h1); wr(5'h0c, 32'h0);
      run <= 1'b1;
      repeat (18) @(posedge ref_clk);
      cmp(irq_req, 1'b0);
      for (j = 0; j < 2; j = j + 1) begin
        wait_irq;
        // width mode: the first request follows the rise, the next the fall
        cmp(lvl, m == 2 ? (j == 0) : (m == 1));
        rd(5'h08); cmp(q, m < 2 ? 32'd15 : lvl ? 32'd9 : 32'd5);
        wr(5'h0c, 32'h0);
      end
    end
    wr(5'h00, 32'hc); wr(5'h0c, 32'h0);
    repeat (100) @(posedge ref_clk);
    cmp(irq_req, 1'b0);
    $display("measure test done");
    conclude;
  end
endmodule // pulse_period_width_timer_tb
